/* File: rtl/amc_config_seq.sv */
`timescale 1ns/10ps
`include "amc_map.svh"
// register file and mode control for the interleaved converter
module amc_config_seq
	import amc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic active_low_clear_pin,
	input wire logic sleep_request_pin,
	input wire logic sclk_pin,
	input wire logic sdata_pin,
	input wire logic csel_n_pin,
	input wire logic [7:0] rd_addr,
	output logic [15:0] rd_data,
	output logic powered_down,
	output amc_mode_type chan_mode,
	output logic [2:0] clk_divider,
	output amc_route_type route,
	output logic [15:0] bit_clock_phase,
	output logic mode_changed_active
);
	logic [1:0] clr_s_q;
	logic [1:0] slp_s_q;
	logic clr_prev_q;
	logic wr_valid;
	amc_write_type wr_word;
	logic [15:0] power_q;
	logic [15:0] mode_q;
	logic [15:0] route_a_q;
	logic [15:0] route_b_q;
	logic [15:0] phase_q;
	logic viol_q;

	// hardware detects the clock format; no register selects it
	// everything below runs on the rising edge only
	amc_serial_rx #(
		.FRAME_BITS(`AMC_FRAME_BITS)
	) u_rx (
		.clk_sys(clk_sys),
		.srst(srst),
		.sclk_pin(sclk_pin),
		.sdata_pin(sdata_pin),
		.csel_n_pin(csel_n_pin),
		.wr_valid(wr_valid),
		.wr_word(wr_word)
	);

	always_ff @(posedge clk_sys) begin
		clr_s_q <= {clr_s_q[0], active_low_clear_pin};
		slp_s_q <= {slp_s_q[0], sleep_request_pin};
		clr_prev_q <= clr_s_q[1];
	end

	wire wr_reset = wr_valid && wr_word.addr == `AMC_ADDR_RESET &&
		wr_word.data == `AMC_VAL_RESET;
	wire pin_reset = clr_prev_q & ~clr_s_q[1];
	wire soft_clr = srst | wr_reset | pin_reset | ~clr_s_q[1];
	wire wr_power = wr_valid && wr_word.addr == `AMC_ADDR_POWER;
	wire wr_mode = wr_valid && wr_word.addr == `AMC_ADDR_MODE;
	wire wr_route_a = wr_valid && wr_word.addr == `AMC_ADDR_ROUTE_A;
	wire wr_route_b = wr_valid && wr_word.addr == `AMC_ADDR_ROUTE_B;
	wire wr_phase = wr_valid && wr_word.addr == `AMC_ADDR_PHASE;
	wire reg_sleep = power_q == `AMC_VAL_SLEEP;
	wire sleep_now = slp_s_q[1] | reg_sleep;
	wire mode_ok = wr_word.data == `AMC_VAL_SINGLE ||
		wr_word.data == `AMC_VAL_DUAL || wr_word.data == `AMC_VAL_QUAD;

	always_ff @(posedge clk_sys) begin
		if (soft_clr) begin
			power_q <= `AMC_RST_POWER;
			mode_q <= `AMC_RST_MODE;
			route_a_q <= `AMC_RST_ROUTE;
			route_b_q <= `AMC_RST_ROUTE;
			phase_q <= `AMC_RST_PHASE;
			viol_q <= 1'b0;
		end else begin
			if (wr_power) begin
				power_q <= wr_word.data;
			end
			if (wr_phase) begin
				phase_q <= wr_word.data;
			end
			if (wr_mode && mode_ok) begin
				mode_q <= wr_word.data;
				viol_q <= viol_q | ~sleep_now;
			end
			// routing lands the cycle after wr_valid flags its completed write
			if (wr_route_a) begin
				route_a_q <= wr_word.data;
			end
			if (wr_route_b) begin
				route_b_q <= wr_word.data;
			end
		end
	end

	assign powered_down = sleep_now;
	assign chan_mode = mode_q == `AMC_VAL_QUAD ? AMC_QUAD :
		mode_q == `AMC_VAL_DUAL ? AMC_DUAL : AMC_SINGLE;
	assign clk_divider = mode_q[2:0];
	assign route.ch1 = route_a_q[15:8];
	assign route.ch2 = route_a_q[7:0];
	assign route.ch3 = route_b_q[15:8];
	assign route.ch4 = route_b_q[7:0];
	assign bit_clock_phase = phase_q;
	assign mode_changed_active = viol_q;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_data <= 16'h0000;
		end else if (rd_addr == `AMC_ADDR_POWER) begin
			rd_data <= power_q;
		end else if (rd_addr == `AMC_ADDR_MODE) begin
			rd_data <= mode_q;
		end else if (rd_addr == `AMC_ADDR_ROUTE_A) begin
			rd_data <= route_a_q;
		end else if (rd_addr == `AMC_ADDR_ROUTE_B) begin
			rd_data <= route_b_q;
		end else if (rd_addr == `AMC_ADDR_PHASE) begin
			rd_data <= phase_q;
		end else begin
			rd_data <= 16'h0000;
		end
	end
endmodule // amc_config_seq

/* File: rtl/amc_map.svh */
// Behaviour
// - all internal timing uses only the rising edge of the converter clock.
// - clock format is detected by hardware, no register setting needed.
// - reset by low pulse on clear pin or writing 0x0001 to address 0x00.
// - power-down by pin high or 0x0200 at 0x0F; active by low or 0x0000 (code: active only with pin low and 0x0F not 0x0200).
// - 0x31 selects mode and divider: 0x0001, 0x0102, 0x0204.
// - routing changes accepted while active without power-down.
// - routing change takes effect at the end of its serial write.
// - routing at 0x3A and 0x3B, byte per slot, one-hot input codes.
// - quad mode: 0x3A bytes route ch1/ch2, 0x3B bytes route ch3/ch4.
`ifndef AMC_MAP_SVH
`define AMC_MAP_SVH
`define AMC_ADDR_RESET 8'h00
`define AMC_ADDR_POWER 8'h0f
`define AMC_ADDR_MODE 8'h31
`define AMC_ADDR_ROUTE_A 8'h3a
`define AMC_ADDR_ROUTE_B 8'h3b
`define AMC_ADDR_PHASE 8'h42
`define AMC_VAL_RESET 16'h0001
`define AMC_VAL_SLEEP 16'h0200
`define AMC_VAL_AWAKE 16'h0000
`define AMC_VAL_SINGLE 16'h0001
`define AMC_VAL_DUAL 16'h0102
`define AMC_VAL_QUAD 16'h0204
`define AMC_RST_MODE 16'h0001
`define AMC_RST_ROUTE 16'h0202
`define AMC_RST_PHASE 16'h0000
`define AMC_RST_POWER 16'h0000
`define AMC_FRAME_BITS 24
`endif

/* File: rtl/amc_pkg.sv */
package amc_pkg;
	typedef enum logic [2:0] {
		AMC_SINGLE = 3'b001,
		AMC_DUAL = 3'b010,
		AMC_QUAD = 3'b100
	} amc_mode_type;
	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] data;
	} amc_write_type;
	typedef struct packed {
		logic [7:0] ch1;
		logic [7:0] ch2;
		logic [7:0] ch3;
		logic [7:0] ch4;
	} amc_route_type;
endpackage

/* File: rtl/amc_serial_rx.sv */
`timescale 1ns/10ps
// serial write receiver: 8-bit address then 16-bit data, msb first
module amc_serial_rx
	import amc_pkg::*;
#(
	parameter int FRAME_BITS = 24
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic sclk_pin,
	input wire logic sdata_pin,
	input wire logic csel_n_pin,
	output logic wr_valid,
	output amc_write_type wr_word
);
	logic [2:0] sclk_s_q;
	logic [1:0] sdata_s_q;
	logic [1:0] csel_s_q;
	logic [23:0] shift_q;
	logic [4:0] count_q;
	wire sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
	wire csel_act = ~csel_s_q[1];
	wire frame_done = sclk_rise & csel_act &
		(count_q == 5'(FRAME_BITS - 1));
	always_ff @(posedge clk_sys) begin
		sclk_s_q <= {sclk_s_q[1:0], sclk_pin};
		sdata_s_q <= {sdata_s_q[0], sdata_pin};
		csel_s_q <= {csel_s_q[0], csel_n_pin};
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			shift_q <= 24'h000000;
			count_q <= 5'h00;
			wr_valid <= 1'b0;
		end else begin
			wr_valid <= frame_done;
			if (!csel_act) begin
				count_q <= 5'h00;
			end else if (sclk_rise) begin
				shift_q <= {shift_q[22:0], sdata_s_q[1]};
				count_q <= frame_done ? 5'h00 : count_q + 5'h01;
			end
		end
	end
	assign wr_word = shift_q;
endmodule // amc_serial_rx

/* File: verif/adc_mode_config_sequencer_bench.sv */
`timescale 1ns/10ps
module adc_mode_config_sequencer_bench;
	import amc_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic active_low_clear_pin = 1'b1;
	logic sleep_request_pin = 1'b0;
	logic sclk_pin, sdata_pin, csel_n_pin, powered_down, mode_changed_active;
	logic [7:0] rd_addr = 8'h00;
	logic [15:0] rd_data, bit_clock_phase;
	logic [2:0] clk_divider;
	amc_mode_type chan_mode;
	amc_route_type route;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [7:0] ra[7] = '{8'h00, 8'h0f, 8'h31, 8'h3a, 8'h3b, 8'h42, 8'h55};
	logic [15:0] rv[7] = '{16'h0, 16'h0, 16'h1, 16'h0202, 16'h0202, 16'h0, 16'h0};
	logic [15:0] mv[3] = '{16'h0001, 16'h0102, 16'h0204};
	initial forever #10 clk_sys = ~clk_sys;
	amc_config_seq dut (.*);
	amc_host_model host (.*);
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		rd_addr <= a;
		repeat (2) @(posedge clk_sys);
		check(rd_data, e);
	endtask
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		foreach (ra[i]) rd(ra[i], rv[i]);
		$display("reset test done");
		host.send(8'h00, 16'h0001);
		host.send(8'h0f, 16'h0200);
		check(powered_down, 1'b1);
		host.send(8'h42, 16'h0005);
		check(bit_clock_phase, 16'h0005);
		rd(8'h42, 16'h0005);
		host.send(8'h31, 16'h0102);
		host.send(8'h0f, 16'h0000);
		check({chan_mode, clk_divider, powered_down}, 7'h24);
		host.send(8'h3a, 16'h0202);
		host.send(8'h3b, 16'h0808);
		check(route, 32'h02020808);
		for (int i = 0; i < 3; i++) begin
			sleep_request_pin <= 1'b1;
			repeat (4) @(posedge clk_sys);
			host.send(8'h31, mv[i]);
			sleep_request_pin <= 1'b0;
			repeat (4) @(posedge clk_sys);
			check({chan_mode, clk_divider}, {2{mv[i][2:0]}});
		end
		host.send(8'h3a, 16'h1008);
		check(route.ch1, 8'h10);
		host.send(8'h3b, 16'h0402);
		check({mode_changed_active, route}, 33'h010080402);
		host.send(8'h31, 16'h0003);
		check(chan_mode, AMC_QUAD);
		host.send(8'h31, 16'h0001);
		check(mode_changed_active, 1'b1);
		$display("mode test done");
		host.send(8'h00, 16'h0001);
		check({mode_changed_active, route}, 33'h002020202);
		host.send(8'h3a, 16'h1010);
		active_low_clear_pin <= 1'b0;
		repeat (4) @(posedge clk_sys);
		active_low_clear_pin <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(route, 32'h02020202);
		$display("clear test done");
		print_verdict();
	end
endmodule // adc_mode_config_sequencer_bench

/* File: verif/amc_config_seq_properties.sv */
`timescale 1ns/10ps
module amc_config_seq_properties
	import amc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic active_low_clear_pin,
	input wire logic sleep_request_pin,
	input wire logic csel_n_pin,
	input wire logic [7:0] rd_addr,
	input wire logic [15:0] rd_data,
	input wire logic powered_down,
	input wire amc_mode_type chan_mode,
	input wire logic [2:0] clk_divider,
	input wire amc_route_type route
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	a_mode_legal: assert property (
		chan_mode inside {AMC_SINGLE, AMC_DUAL, AMC_QUAD})
		else $error("bad mode");
	a_divider_mode: assert property (
		clk_divider == chan_mode)
		else $error("divider off");
	a_pin_sleep: assert property (
		sleep_request_pin [*3] |=> powered_down)
		else $error("no sleep");
	a_reset_values: assert property (
		$fell(srst) |-> route == 32'h02020202)
		else $error("route not reset");
	a_clear_pin: assert property (
		!active_low_clear_pin [*3] |=> route == 32'h02020202)
		else $error("pin reset missed");
	a_route_quiet: assert property (
		(csel_n_pin && active_low_clear_pin) [*8] |-> $stable(route))
		else $error("route moved");
	a_rd_reset_reg: assert property (
		rd_addr == 8'h00 |=> rd_data == 16'h0000)
		else $error("wo read");
	a_rd_route: assert property (
		rd_addr == 8'h3a |=>
		rd_data == {$past(route.ch1), $past(route.ch2)})
		else $error("route read");
endmodule // amc_config_seq_properties
bind amc_config_seq amc_config_seq_properties chk (.*);

/* File: verif/amc_host_model.sv */
`timescale 1ns/10ps
module amc_host_model (
	input wire logic clk_sys,
	output logic sclk_pin,
	output logic sdata_pin,
	output logic csel_n_pin
);
	initial begin
		sclk_pin = 1'b0;
		sdata_pin = 1'b0;
		csel_n_pin = 1'b1;
	end
	// one whole frame, msb first; data idles at the inverse of its last bit
	task automatic send(input logic [7:0] a, input logic [15:0] d);
		logic [23:0] w;
		w = {a, d};
		for (int i = 23; i >= 0; i--) begin
			csel_n_pin <= 1'b0;
			sdata_pin <= w[i];
			repeat (2) @(posedge clk_sys);
			sclk_pin <= 1'b1;
			repeat (2) @(posedge clk_sys);
			sclk_pin <= 1'b0;
		end
		repeat (2) @(posedge clk_sys);
		csel_n_pin <= 1'b1;
		sdata_pin <= ~w[0];
		repeat (8) @(posedge clk_sys);
	endtask
endmodule // amc_host_model
